//--- inc/mcuic_pkg.sv
// mcuic_pkg: constants, register map and carrier types of the interrupt controller
// assumes an 8-bit special-function-register port driven by the core on sys_clk
`default_nettype none

package mcuic_pkg;

  // register addresses on the special-function-register port
  localparam logic [7:0] ADDR_ENABLE      = 8'ha8;
  localparam logic [7:0] ADDR_ENABLE_LVL2 = 8'ha9;
  localparam logic [7:0] ADDR_LEVEL       = 8'hb8;
  localparam logic [7:0] ADDR_TIMER01_CTL = 8'h88;

  // reset values
  localparam logic [7:0] RST_ENABLE      = 8'h00;
  localparam logic [7:0] RST_ENABLE_LVL2 = 8'ha0;
  localparam logic [7:0] RST_LEVEL       = 8'h00;

  // irq_enable_reg fields
  localparam int GLOBAL_IRQ_GATE = 7;
  localparam int THERMO_IRQ_ON   = 6;
  localparam int TIMER2_IRQ_ON   = 5;
  localparam int UART_IRQ_ON     = 4;
  localparam int TIMER1_IRQ_ON   = 3;
  localparam int PIN1_IRQ_ON     = 2;
  localparam int TIMER0_IRQ_ON   = 1;
  localparam int PIN0_IRQ_ON     = 0;

  // irq_level_reg fields
  localparam int METER_IRQ_HIGH  = 7;
  localparam int THERMO_IRQ_HIGH = 6;
  localparam int TIMER2_IRQ_HIGH = 5;
  localparam int UART_IRQ_HIGH   = 4;
  localparam int TIMER1_IRQ_HIGH = 3;
  localparam int PIN1_IRQ_HIGH   = 2;
  localparam int TIMER0_IRQ_HIGH = 1;
  localparam int PIN0_IRQ_HIGH   = 0;

  // irq_enable_level_2 fields
  localparam int UART_B_IRQ_HIGH     = 7;
  localparam int CLOCK_IRQ_HIGH      = 6;
  localparam int UART_B_IRQ_ON       = 5;
  localparam int SERIAL_BUS_IRQ_HIGH = 4;
  localparam int METER_IRQ_ON        = 3;
  localparam int CLOCK_IRQ_ON        = 2;
  localparam int SUPPLY_IRQ_ON       = 1;
  localparam int SERIAL_BUS_IRQ_ON   = 0;

  // timer01_control_reg flag positions held here
  localparam int PIN0_FLAG_BIT = 1;
  localparam int PIN1_FLAG_BIT = 3;

  // sources, numbered in polling order, 0 first
  localparam int NSRC        = 13;
  localparam int SRC_SUPPLY  = 0;
  localparam int SRC_CLOCK   = 1;
  localparam int SRC_METER   = 2;
  localparam int SRC_WDOG    = 3;
  localparam int SRC_THERMO  = 4;
  localparam int SRC_PIN0    = 5;
  localparam int SRC_TIMER0  = 6;
  localparam int SRC_PIN1    = 7;
  localparam int SRC_TIMER1  = 8;
  localparam int SRC_SERIAL  = 9;
  localparam int SRC_UART    = 10;
  localparam int SRC_TIMER2  = 11;
  localparam int SRC_UART_B  = 12;

  // vector address = base + step * slot
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // service levels held in the active mask
  localparam int LVL_LOW  = 0;
  localparam int LVL_HIGH = 1;
  localparam int LVL_TOP  = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mcuic_sfr_t;

  typedef struct packed {
    logic supply_event_flag;
    logic clock_alarm_flag;
    logic clock_interval_flag;
    logic meter_event_flag;
    logic watchdog_expiry_flag;
    logic thermo_event;
    logic serial_bus_event;
    logic timer0_wrap_flag;
    logic timer1_wrap_flag;
    logic timer2_wrap_flag;
    logic timer2_pin_flag;
    logic uart_tx_done;
    logic uart_rx_done;
    logic uart_b_tx_done;
    logic uart_b_rx_done;
  } mcuic_src_t;

  typedef struct packed {
    logic irq_ack;
    logic reti;
    logic instr_done;
  } mcuic_core_t;

endpackage

`default_nettype wire

//--- core/mcuic_pin_sync.sv
// mcuic_pin_sync: two-flop synchroniser and falling-edge detector for an interrupt pin
// assumes an asynchronous pin that idles high
`default_nettype none

module mcuic_pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_n,
  output logic      pin_low,
  output logic      pin_fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mcuic_sync_st_t;

  mcuic_sync_st_t st_q;
  mcuic_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_n;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= 3'b111;
    end else begin
      st_q <= st_d;
    end
  end

  // only the second and third stages are looked at
  assign pin_low  = ~st_q.s2;
  assign pin_fall = st_q.s3 & ~st_q.s2;

endmodule

`default_nettype wire

//--- core/mcuic_poll_pick.sv
// mcuic_poll_pick: picks the first set request in polling order
// assumes bit 0 is polled first
`default_nettype none

module mcuic_poll_pick (
  input  wire logic [12:0] req,
  output logic             found,
  output logic [3:0]       idx
);

  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = 4'(i);
      end
    end
  end

endmodule

`default_nettype wire

//--- core/mcuic_ctrl.sv
// mcuic_ctrl: interrupt controller of a small microcontroller core
// assumes the core drives the register port, acks vectors and reports reti on sys_clk
//
// What this block does
// - enable bit 7 gates every source
// - per-source enables in enable register bits 6-0
// - level register: one high/low bit for each of eight sources
// - second register bits 7,6,4 set levels
// - second register bits 5,3,2,1,0 enable sources
// - fixed polling order within one level
// - supply request alone at top level
// - external wake leaves pending external interrupt
// - shutdown events leave pin flags untouched
// - thermo and serial-bus requests latched until vectored
// - serial status clears keep pending serial request
// - clock request follows alarm or interval flag
// - vectoring does not clear clock request
// - multi-source vectors not cleared on entry
// - pin flag cleared on vectoring only edge-triggered
// - low-level pin keeps requesting while low
// - timer 2 request is wrap or pin flag
// - supply and meter requests from their flags
// - thermo pending state has no visible flag
// - high preempts low, never same level
// - vector is base plus eight per slot
// - no vectoring right after reti or enable/level register access
`default_nettype none

module mcuic_ctrl (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire mcuic_pkg::mcuic_sfr_t  sfr,
  output logic [7:0]                sfr_rdata,
  output logic                      sfr_hit,
  input  wire mcuic_pkg::mcuic_src_t  src,
  input  wire logic                 int0_n,
  input  wire logic                 int1_n,
  input  wire logic                 pin0_edge_select,
  input  wire logic                 pin1_edge_select,
  input  wire logic                 watchdog_irq_mode,
  input  wire logic                 core_shutdown_mode,
  input  wire mcuic_pkg::mcuic_core_t core,
  output logic                      irq_req,
  output logic [15:0]               irq_vector,
  output logic                      pin0_flag,
  output logic                      pin1_flag
);

  typedef struct packed {
    logic [7:0]  irq_enable_reg;
    logic [7:0]  irq_enable_level_2;
    logic [7:0]  irq_level_reg;
    logic        pin0_flag;
    logic        pin1_flag;
    logic        pin0_wake;
    logic        pin1_wake;
    logic        thermo_request;
    logic        serial_request;
    logic [2:0]  active;
    logic        hold_off;
    logic        req;
    logic [3:0]  sel_idx;
    logic [1:0]  sel_lvl;
    logic [15:0] vector;
    logic [7:0]  rdata;
    logic        hit;
  } mcuic_st_t;

  mcuic_st_t st_q;
  mcuic_st_t st_d;

  // vector slot of each source
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [3:0] slot;
    slot = 4'h0;
    case (idx)
      4'(mcuic_pkg::SRC_PIN0):   slot = 4'h0;
      4'(mcuic_pkg::SRC_TIMER0): slot = 4'h1;
      4'(mcuic_pkg::SRC_PIN1):   slot = 4'h2;
      4'(mcuic_pkg::SRC_TIMER1): slot = 4'h3;
      4'(mcuic_pkg::SRC_UART):   slot = 4'h4;
      4'(mcuic_pkg::SRC_TIMER2): slot = 4'h5;
      4'(mcuic_pkg::SRC_THERMO): slot = 4'h6;
      4'(mcuic_pkg::SRC_SERIAL): slot = 4'h7;
      4'(mcuic_pkg::SRC_SUPPLY): slot = 4'h8;
      4'(mcuic_pkg::SRC_METER):  slot = 4'h9;
      4'(mcuic_pkg::SRC_CLOCK):  slot = 4'ha;
      4'(mcuic_pkg::SRC_WDOG):   slot = 4'hb;
      4'(mcuic_pkg::SRC_UART_B): slot = 4'hc;
      default:                   slot = 4'h0;
    endcase
    return 16'(mcuic_pkg::VEC_BASE + 16'(mcuic_pkg::VEC_STEP * 16'(slot)));
  endfunction

  // true when the port addresses one of the enable or level registers
  function automatic logic is_irq_reg(input logic [7:0] addr);
    return (addr == mcuic_pkg::ADDR_ENABLE) || (addr == mcuic_pkg::ADDR_ENABLE_LVL2) ||
           (addr == mcuic_pkg::ADDR_LEVEL);
  endfunction

  logic        pin0_low;
  logic        pin0_fall;
  logic        pin1_low;
  logic        pin1_fall;
  logic [12:0] pend;
  logic [12:0] en;
  logic [12:0] hi;
  logic [12:0] live;
  logic [12:0] top_req;
  logic [12:0] hi_req;
  logic [12:0] lo_req;
  logic        top_found;
  logic        hi_found;
  logic        lo_found;
  logic [3:0]  top_idx;
  logic [3:0]  hi_idx;
  logic [3:0]  lo_idx;
  logic        ack;
  logic        reg_touch;

  mcuic_pin_sync u_sync0 (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_n    (int0_n),
    .pin_low  (pin0_low),
    .pin_fall (pin0_fall)
  );

  mcuic_pin_sync u_sync1 (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_n    (int1_n),
    .pin_low  (pin1_low),
    .pin_fall (pin1_fall)
  );

  // pending, enable and level vectors in polling order
  always_comb begin
    pend = '0;
    en   = '0;
    hi   = '0;
    pend[mcuic_pkg::SRC_SUPPLY] = src.supply_event_flag;
    pend[mcuic_pkg::SRC_CLOCK]  = src.clock_alarm_flag | src.clock_interval_flag;
    pend[mcuic_pkg::SRC_METER]  = src.meter_event_flag;
    pend[mcuic_pkg::SRC_WDOG]   = src.watchdog_expiry_flag & watchdog_irq_mode;
    pend[mcuic_pkg::SRC_THERMO] = st_q.thermo_request;
    pend[mcuic_pkg::SRC_PIN0]   = st_q.pin0_flag | st_q.pin0_wake;
    pend[mcuic_pkg::SRC_TIMER0] = src.timer0_wrap_flag;
    pend[mcuic_pkg::SRC_PIN1]   = st_q.pin1_flag | st_q.pin1_wake;
    pend[mcuic_pkg::SRC_TIMER1] = src.timer1_wrap_flag;
    pend[mcuic_pkg::SRC_SERIAL] = st_q.serial_request;
    pend[mcuic_pkg::SRC_UART]   = src.uart_tx_done | src.uart_rx_done;
    pend[mcuic_pkg::SRC_TIMER2] = src.timer2_wrap_flag | src.timer2_pin_flag;
    pend[mcuic_pkg::SRC_UART_B] = src.uart_b_tx_done | src.uart_b_rx_done;

    en[mcuic_pkg::SRC_SUPPLY] = st_q.irq_enable_level_2[mcuic_pkg::SUPPLY_IRQ_ON];
    en[mcuic_pkg::SRC_CLOCK]  = st_q.irq_enable_level_2[mcuic_pkg::CLOCK_IRQ_ON];
    en[mcuic_pkg::SRC_METER]  = st_q.irq_enable_level_2[mcuic_pkg::METER_IRQ_ON];
    en[mcuic_pkg::SRC_WDOG]   = 1'b1;
    en[mcuic_pkg::SRC_THERMO] = st_q.irq_enable_reg[mcuic_pkg::THERMO_IRQ_ON];
    en[mcuic_pkg::SRC_PIN0]   = st_q.irq_enable_reg[mcuic_pkg::PIN0_IRQ_ON];
    en[mcuic_pkg::SRC_TIMER0] = st_q.irq_enable_reg[mcuic_pkg::TIMER0_IRQ_ON];
    en[mcuic_pkg::SRC_PIN1]   = st_q.irq_enable_reg[mcuic_pkg::PIN1_IRQ_ON];
    en[mcuic_pkg::SRC_TIMER1] = st_q.irq_enable_reg[mcuic_pkg::TIMER1_IRQ_ON];
    en[mcuic_pkg::SRC_SERIAL] = st_q.irq_enable_level_2[mcuic_pkg::SERIAL_BUS_IRQ_ON];
    en[mcuic_pkg::SRC_UART]   = st_q.irq_enable_reg[mcuic_pkg::UART_IRQ_ON];
    en[mcuic_pkg::SRC_TIMER2] = st_q.irq_enable_reg[mcuic_pkg::TIMER2_IRQ_ON];
    en[mcuic_pkg::SRC_UART_B] = st_q.irq_enable_level_2[mcuic_pkg::UART_B_IRQ_ON];

    hi[mcuic_pkg::SRC_CLOCK]  = st_q.irq_enable_level_2[mcuic_pkg::CLOCK_IRQ_HIGH];
    hi[mcuic_pkg::SRC_METER]  = st_q.irq_level_reg[mcuic_pkg::METER_IRQ_HIGH];
    hi[mcuic_pkg::SRC_WDOG]   = 1'b1;
    hi[mcuic_pkg::SRC_THERMO] = st_q.irq_level_reg[mcuic_pkg::THERMO_IRQ_HIGH];
    hi[mcuic_pkg::SRC_PIN0]   = st_q.irq_level_reg[mcuic_pkg::PIN0_IRQ_HIGH];
    hi[mcuic_pkg::SRC_TIMER0] = st_q.irq_level_reg[mcuic_pkg::TIMER0_IRQ_HIGH];
    hi[mcuic_pkg::SRC_PIN1]   = st_q.irq_level_reg[mcuic_pkg::PIN1_IRQ_HIGH];
    hi[mcuic_pkg::SRC_TIMER1] = st_q.irq_level_reg[mcuic_pkg::TIMER1_IRQ_HIGH];
    hi[mcuic_pkg::SRC_SERIAL] = st_q.irq_enable_level_2[mcuic_pkg::SERIAL_BUS_IRQ_HIGH];
    hi[mcuic_pkg::SRC_UART]   = st_q.irq_level_reg[mcuic_pkg::UART_IRQ_HIGH];
    hi[mcuic_pkg::SRC_TIMER2] = st_q.irq_level_reg[mcuic_pkg::TIMER2_IRQ_HIGH];
    hi[mcuic_pkg::SRC_UART_B] = st_q.irq_enable_level_2[mcuic_pkg::UART_B_IRQ_HIGH];
  end

  // global gate, then split into the three levels
  always_comb begin
    live    = pend & en & {13{st_q.irq_enable_reg[mcuic_pkg::GLOBAL_IRQ_GATE]}};
    top_req = '0;
    top_req[mcuic_pkg::SRC_SUPPLY] = live[mcuic_pkg::SRC_SUPPLY];
    hi_req  = live & hi & ~top_req;
    lo_req  = live & ~hi & ~top_req;
  end

  mcuic_poll_pick u_pick_top (
    .req   (top_req),
    .found (top_found),
    .idx   (top_idx)
  );

  mcuic_poll_pick u_pick_hi (
    .req   (hi_req),
    .found (hi_found),
    .idx   (hi_idx)
  );

  mcuic_poll_pick u_pick_lo (
    .req   (lo_req),
    .found (lo_found),
    .idx   (lo_idx)
  );

  assign ack       = core.irq_ack & st_q.req;
  assign reg_touch = (sfr.wr | sfr.rd) & is_irq_reg(sfr.addr);

  always_comb begin
    st_d = st_q;

    // register writes
    if (sfr.wr) begin
      case (sfr.addr)
        mcuic_pkg::ADDR_ENABLE:      st_d.irq_enable_reg     = sfr.wdata;
        mcuic_pkg::ADDR_ENABLE_LVL2: st_d.irq_enable_level_2 = sfr.wdata;
        mcuic_pkg::ADDR_LEVEL:       st_d.irq_level_reg      = sfr.wdata;
        mcuic_pkg::ADDR_TIMER01_CTL: begin
          st_d.pin0_flag = sfr.wdata[mcuic_pkg::PIN0_FLAG_BIT];
          st_d.pin1_flag = sfr.wdata[mcuic_pkg::PIN1_FLAG_BIT];
        end
        default: ;
      endcase
    end

    // register reads, answered one cycle later
    st_d.hit   = sfr.rd & is_irq_reg(sfr.addr);
    st_d.rdata = 8'h00;
    if (sfr.rd) begin
      case (sfr.addr)
        mcuic_pkg::ADDR_ENABLE:      st_d.rdata = st_q.irq_enable_reg;
        mcuic_pkg::ADDR_ENABLE_LVL2: st_d.rdata = st_q.irq_enable_level_2;
        mcuic_pkg::ADDR_LEVEL:       st_d.rdata = st_q.irq_level_reg;
        default:                     st_d.rdata = 8'h00;
      endcase
    end

    // clears on vectoring
    if (ack) begin
      st_d.active[st_q.sel_lvl] = 1'b1;
      case (st_q.sel_idx)
        4'(mcuic_pkg::SRC_PIN0): begin
          st_d.pin0_wake = 1'b0;
          if (pin0_edge_select) begin
            st_d.pin0_flag = 1'b0;
          end
        end
        4'(mcuic_pkg::SRC_PIN1): begin
          st_d.pin1_wake = 1'b0;
          if (pin1_edge_select) begin
            st_d.pin1_flag = 1'b0;
          end
        end
        4'(mcuic_pkg::SRC_THERMO): st_d.thermo_request = 1'b0;
        4'(mcuic_pkg::SRC_SERIAL): st_d.serial_request = 1'b0;
        default: ; // clock and multi-source requests stay with their flags
      endcase
    end

    // latched requests, set wins over clear
    if (src.thermo_event) begin
      st_d.thermo_request = 1'b1;
    end
    if (src.serial_bus_event) begin
      st_d.serial_request = 1'b1;
    end

    // pin flags and wake latches
    if (core_shutdown_mode) begin
      st_d.pin0_flag = st_q.pin0_flag;
      st_d.pin1_flag = st_q.pin1_flag;
      if (pin0_low) begin
        st_d.pin0_wake = 1'b1;
      end
      if (pin1_low) begin
        st_d.pin1_wake = 1'b1;
      end
    end else begin
      if (pin0_edge_select) begin
        if (pin0_fall) begin
          st_d.pin0_flag = 1'b1;
        end
      end else begin
        st_d.pin0_flag = pin0_low;
      end
      if (pin1_edge_select) begin
        if (pin1_fall) begin
          st_d.pin1_flag = 1'b1;
        end
      end else begin
        st_d.pin1_flag = pin1_low;
      end
    end

    // return from interrupt frees the highest active level
    if (core.reti) begin
      if (st_q.active[mcuic_pkg::LVL_TOP]) begin
        st_d.active[mcuic_pkg::LVL_TOP] = 1'b0;
      end else if (st_q.active[mcuic_pkg::LVL_HIGH]) begin
        st_d.active[mcuic_pkg::LVL_HIGH] = 1'b0;
      end else begin
        st_d.active[mcuic_pkg::LVL_LOW] = 1'b0;
      end
    end

    // hold-off until one instruction completes
    if (core.reti || reg_touch || ack) begin
      st_d.hold_off = 1'b1;
    end else if (core.instr_done) begin
      st_d.hold_off = 1'b0;
    end

    // level choice: only a strictly higher level preempts
    st_d.req = 1'b0;
    if (top_found && !st_q.active[mcuic_pkg::LVL_TOP]) begin
      st_d.req     = 1'b1;
      st_d.sel_idx = top_idx;
      st_d.sel_lvl = 2'(mcuic_pkg::LVL_TOP);
    end else if (hi_found && st_q.active[mcuic_pkg::LVL_TOP:mcuic_pkg::LVL_HIGH] == 2'b00) begin
      st_d.req     = 1'b1;
      st_d.sel_idx = hi_idx;
      st_d.sel_lvl = 2'(mcuic_pkg::LVL_HIGH);
    end else if (lo_found && st_q.active == 3'b000) begin
      st_d.req     = 1'b1;
      st_d.sel_idx = lo_idx;
      st_d.sel_lvl = 2'(mcuic_pkg::LVL_LOW);
    end
    if (st_d.hold_off || st_q.hold_off || core_shutdown_mode) begin
      st_d.req = 1'b0;
    end
    st_d.vector = vec_of(st_d.sel_idx);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q                    <= '0;
      st_q.irq_enable_reg     <= mcuic_pkg::RST_ENABLE;
      st_q.irq_enable_level_2 <= mcuic_pkg::RST_ENABLE_LVL2;
      st_q.irq_level_reg      <= mcuic_pkg::RST_LEVEL;
      st_q.vector             <= mcuic_pkg::VEC_BASE;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata  = st_q.rdata;
  assign sfr_hit    = st_q.hit;
  assign irq_req    = st_q.req;
  assign irq_vector = st_q.vector;
  assign pin0_flag  = st_q.pin0_flag;
  assign pin1_flag  = st_q.pin1_flag;

endmodule

`default_nettype wire

//--- sim/mcuic_core_model.sv
// mcuic_core_model: core side that acks vectors, retires instructions and returns
// assumes mcuic_ctrl on the same sys_clk; lag sets how long an ack waits
`default_nettype none

module mcuic_core_model (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               irq_req,
  input  wire logic [15:0]        irq_vector,
  input  wire logic               reti_go,
  input  wire logic [3:0]         lag,
  output var mcuic_pkg::mcuic_core_t core,
  output var logic [15:0]         last_vec,
  output var logic                took
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic       ack_d;

  assign ack_d = irq_req && !core.irq_ack && (wait_q >= lag);

  always_ff @(posedge sys_clk) begin
    took <= 1'b0;
    if (!rst_n) begin
      core <= '0;
      wait_q <= 4'h0;
      last_vec <= 16'h0000;
    end else begin
      wait_q <= (irq_req && !core.irq_ack) ? wait_q + 4'h1 : 4'h0;
      // ack only while a request stands
      core.irq_ack <= ack_d;
      core.reti <= reti_go;
      // one instruction retires every other cycle, never with ack or reti
      core.instr_done <= !core.instr_done && !ack_d && !reti_go;
      if (core.irq_ack && irq_req) begin
        last_vec <= irq_vector;
        took <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/mcuic_ctrl_monitor.sv
// mcuic_monitor: port-level assertions for mcuic_ctrl
// assumes a single sys_clk domain with synchronous active-low rst_n
`default_nettype none

module mcuic_monitor (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire mcuic_pkg::mcuic_sfr_t  sfr,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  sfr_hit,
  input wire mcuic_pkg::mcuic_src_t  src,
  input wire logic                  int0_n,
  input wire logic                  int1_n,
  input wire logic                  pin0_edge_select,
  input wire logic                  pin1_edge_select,
  input wire logic                  watchdog_irq_mode,
  input wire logic                  core_shutdown_mode,
  input wire mcuic_pkg::mcuic_core_t core,
  input wire logic                  irq_req,
  input wire logic [15:0]           irq_vector,
  input wire logic                  pin0_flag,
  input wire logic                  pin1_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] en_q;
  logic [7:0] en2_q;
  logic [7:0] lvl_q;

  // shadow copies of the three registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_q <= mcuic_pkg::RST_ENABLE;
      en2_q <= mcuic_pkg::RST_ENABLE_LVL2;
      lvl_q <= mcuic_pkg::RST_LEVEL;
    end else if (sfr.wr) begin
      if (sfr.addr == mcuic_pkg::ADDR_ENABLE) en_q <= sfr.wdata;
      if (sfr.addr == mcuic_pkg::ADDR_ENABLE_LVL2) en2_q <= sfr.wdata;
      if (sfr.addr == mcuic_pkg::ADDR_LEVEL) lvl_q <= sfr.wdata;
    end
  end

  default clocking mcuic_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_gate_needed: assert property ($rose(irq_req) |-> $past(en_q[7]))
    else $error("request raised with gate closed");
  a_slot_shape: assert property (irq_req |-> irq_vector[2:0] == 3'h3 &&
    irq_vector[15:7] == 9'h000 && irq_vector[6:3] <= 4'hc)
    else $error("vector off the slot grid");
  a_reset_state: assert property ($past(!rst_n) |-> !irq_req &&
    irq_vector == 16'h0003 && !sfr_hit && !pin0_flag && !pin1_flag)
    else $error("bad state after reset");
  a_ack_drops: assert property (core.irq_ack && irq_req |=> !irq_req)
    else $error("request kept after ack");
  a_reti_holds: assert property ($past(core.reti) && !irq_req && !core.instr_done
    |=> !irq_req)
    else $error("vectoring right after return");
  a_shut_flags: assert property ($past(core_shutdown_mode) |->
    $stable(pin0_flag) && $stable(pin1_flag))
    else $error("pin flag moved in shutdown");
  a_read_enable: assert property (sfr.rd && sfr.addr == 8'ha8 |=>
    sfr_hit && sfr_rdata == $past(en_q))
    else $error("enable register read wrong");
  a_read_level: assert property (sfr.rd && sfr.addr == 8'hb8 |=>
    sfr_hit && sfr_rdata == $past(lvl_q))
    else $error("level register read wrong");
  a_read_second: assert property (sfr.rd && sfr.addr == 8'ha9 |=>
    sfr_hit && sfr_rdata == $past(en2_q))
    else $error("second register read wrong");
  a_pin_level: assert property ((!pin0_edge_select && !int0_n &&
    !core_shutdown_mode)[*5] |-> pin0_flag)
    else $error("low pin not flagged");
endmodule

bind mcuic_ctrl mcuic_monitor mcuic_monitor_inst (.sys_clk, .rst_n, .sfr, .sfr_rdata,
  .sfr_hit, .src, .int0_n, .int1_n, .pin0_edge_select, .pin1_edge_select,
  .watchdog_irq_mode, .core_shutdown_mode, .core, .irq_req, .irq_vector, .pin0_flag,
  .pin1_flag);

`default_nettype wire

//--- sim/mcuic_ctrl_test.sv
// mcuic_ctrl_test: register and vectoring sequences for mcuic_ctrl
// assumes mcuic_core_model as the core and the bound monitor
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end

module mcuic_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk = 1'b0;
  logic                   rst_n, int0_n, int1_n, core_shutdown_mode, reti_go, took, irq_req;
  logic                   sfr_hit, pin0_flag, pin1_flag, seen;
  logic [3:0]             lag;
  logic [7:0]             sfr_rdata;
  logic [15:0]            irq_vector, last_vec;
  mcuic_pkg::mcuic_sfr_t  sfr;
  mcuic_pkg::mcuic_src_t  src;
  mcuic_pkg::mcuic_core_t core;
  int                     failures = 0, num_checks = 0, cyc = 0;

  always #50 sys_clk = ~sys_clk;

  mcuic_ctrl mcuic_ctrl_inst (.sys_clk, .rst_n, .sfr, .sfr_rdata, .sfr_hit, .src, .int0_n,
    .int1_n, .pin0_edge_select(1'b0), .pin1_edge_select(1'b1), .watchdog_irq_mode(1'b0),
    .core_shutdown_mode, .core, .irq_req, .irq_vector, .pin0_flag, .pin1_flag);
  mcuic_core_model mcuic_core_model_inst (.sys_clk, .rst_n, .irq_req, .irq_vector,
    .reti_go, .lag, .core, .last_vec, .took);

  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk);
    sfr <= '0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    sfr <= '0;
    @(posedge sys_clk);
    `CHK(sfr_rdata, e)
    `CHK(sfr_hit, h)
  endtask

  task automatic serve(input logic [15:0] e);
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (took === 1'b1) break;
    end
    `CHK(took, 1'b1)
    `CHK(last_vec, e)
  endtask

  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      seen = seen | irq_req;
    end
  endtask

  task automatic reti;
    reti_go <= 1'b1;
    @(posedge sys_clk);
    reti_go <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    rst_n = 1'b0; sfr = '0; src = '0; int0_n = 1'b1; int1_n = 1'b1;
    core_shutdown_mode = 1'b0; reti_go = 1'b0; lag = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'ha8, 8'h00, 1'b1);
    rd(8'ha9, 8'ha0, 1'b1);
    rd(8'hb8, 8'h00, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    // timer 0 waits behind a closed gate
    src.timer0_wrap_flag <= 1'b1;
    wr(8'ha8, 8'h0a);
    quiet(10);
    `CHK(seen, 1'b0)
    wr(8'ha8, 8'h8a);
    serve(16'h000b);
    src.timer0_wrap_flag <= 1'b0;
    src.timer1_wrap_flag <= 1'b1;
    quiet(10);
    `CHK(seen, 1'b0)
    // supply preempts a low routine, slow acks
    lag <= 4'h5;
    wr(8'ha9, 8'ha2);
    src.supply_event_flag <= 1'b1;
    serve(16'h0043);
    src.supply_event_flag <= 1'b0;
    reti();
    reti();
    serve(16'h001b);
    src.timer1_wrap_flag <= 1'b0;
    reti();
    // same level together: polling order, meter kept on entry
    lag <= 4'h0;
    wr(8'ha8, 8'h08);
    wr(8'ha9, 8'ha8);
    src.meter_event_flag <= 1'b1;
    src.timer1_wrap_flag <= 1'b1;
    wr(8'ha8, 8'h88);
    serve(16'h004b);
    reti();
    serve(16'h004b);
    src.meter_event_flag <= 1'b0;
    reti();
    serve(16'h001b);
    src.timer1_wrap_flag <= 1'b0;
    reti();
    // level-triggered pin 0 re-enters while low
    wr(8'ha8, 8'h81);
    int0_n <= 1'b0;
    serve(16'h0003);
    reti();
    serve(16'h0003);
    int0_n <= 1'b1;
    reti();
    // latched thermo and serial pulses, clock request held by its flag
    wr(8'ha9, 8'ha5);
    wr(8'ha8, 8'hc0);
    src.thermo_event <= 1'b1;
    src.serial_bus_event <= 1'b1;
    src.clock_alarm_flag <= 1'b1;
    @(posedge sys_clk);
    src.thermo_event <= 1'b0;
    src.serial_bus_event <= 1'b0;
    serve(16'h0053);
    reti();
    serve(16'h0053);
    src.clock_alarm_flag <= 1'b0;
    reti();
    serve(16'h0033);
    reti();
    serve(16'h003b);
    reti();
    quiet(10);
    `CHK(seen, 1'b0)
    // wake from shutdown by pin 1
    wr(8'ha8, 8'h84);
    core_shutdown_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    int1_n <= 1'b0;
    quiet(8);
    `CHK(seen, 1'b0)
    `CHK(pin1_flag, 1'b0)
    core_shutdown_mode <= 1'b0;
    serve(16'h0013);
    int1_n <= 1'b1;
    reti();
    // edge-triggered pin 1 flag cleared on vectoring, no re-entry while low
    int1_n <= 1'b0;
    serve(16'h0013);
    `CHK(pin1_flag, 1'b0)
    reti();
    quiet(10);
    `CHK(seen, 1'b0)
    int1_n <= 1'b1;
    close_out();
  end
endmodule

`default_nettype wire
